//--- hdl/abpc_pkg.sv
// Package for the converter burst power control block.
// Assumes a 100 MHz core clock and an AXI4-Lite register bus.
package abpc_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   // Printed offset 0xba is not a multiple of four: kept as index
   localparam logic [7:0]  POWER_CTL_INDEX    = 8'hba;
   localparam logic [11:0] POWER_CTL_ADDR     = {2'h0, POWER_CTL_INDEX, 2'h0};
   localparam logic [11:0] CONV_CTL_ADDR      = 12'h400;
   localparam logic [11:0] STATUS_ADDR        = 12'h404;
   localparam logic [7:0]  POWER_CTL_RESET    = 8'h0f;
   localparam int          LOW_POWER_BIT      = 7;
   localparam int          DELAY_MSB          = 3;
   localparam int          DELAY_LSB          = 0;
   localparam int          CONV_ON_BIT        = 0;
   localparam int          BURST_SEL_BIT      = 1;
   localparam int          TEN_BIT_MODE_BIT   = 2;
   localparam int          SAR_DIV_LSB        = 8;
   localparam int          SAR_DIV_MSB        = 15;
   localparam logic [7:0]  SAR_DIV_RESET      = 8'h0c;
   localparam logic [1:0]  RESP_OKAY          = 2'h0;
   localparam logic [1:0]  RESP_SLVERR        = 2'h2;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int          CLK_PERIOD_PS      = 10000;
   localparam int          DELAY_STEP_PS      = 400000;
   // Least time: round up
   localparam int          DELAY_STEP_CYCLES  =
      (DELAY_STEP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int          CONV_SAR_10BIT     = 13;
   localparam int          CONV_SAR_8BIT      = 11;

   typedef enum logic [1:0] {
      ABPC_OFF,
      ABPC_IDLE,
      ABPC_WAKE,
      ABPC_CONV
   } abpc_state_t;

   typedef struct packed {
      logic       converter_low_power_sel;
      logic [3:0] powerup_delay_code;
   } abpc_pwr_cfg_t;

   typedef struct packed {
      logic       converter_on;
      logic       burst_mode_sel;
      logic       ten_bit_mode;
      logic [7:0] sar_div;
   } abpc_conv_cfg_t;

endpackage

//--- hdl/abpc_top.sv
// Converter burst power control: power state and start-up delay.
// Assumes synchronous start requests and an AXI4-Lite master.
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps

module abpc_top
   import abpc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output      logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output      logic        s_axi_wready,
   output      logic [1:0]  s_axi_bresp,
   output      logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output      logic        s_axi_arready,
   output      logic [31:0] s_axi_rdata,
   output      logic [1:0]  s_axi_rresp,
   output      logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        conv_start,
   output      logic        conv_powered,
   output      logic        conv_low_power,
   output      logic        conv_busy,
   output      logic        conv_done
);
   import abpc_pkg::*;

   abpc_pwr_cfg_t  pwr;
   abpc_conv_cfg_t cfg;
   abpc_state_t    state;
   logic [11:0]    aw_addr;
   logic [31:0]    w_data;
   logic [3:0]     w_strb;
   logic           aw_held;
   logic           w_held;
   logic [11:0]    wake_cnt;
   logic [7:0]     div_cnt;
   logic [3:0]     sar_cnt;
   logic           start_pend;

   // ************************************************************
   // AXI4-Lite write path
   // ************************************************************
   wire do_write = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         aw_held       <= 1'b0;
         w_held        <= 1'b0;
         aw_addr       <= 12'h000;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            if (aw_addr == POWER_CTL_ADDR || aw_addr == CONV_CTL_ADDR
                || aw_addr == STATUS_ADDR)
               s_axi_bresp <= RESP_OKAY;
            else
               s_axi_bresp <= RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // ************************************************************
   // Configuration registers
   // ************************************************************
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         pwr <= '{converter_low_power_sel: POWER_CTL_RESET[LOW_POWER_BIT],
                  powerup_delay_code: POWER_CTL_RESET[DELAY_MSB:DELAY_LSB]};
         cfg <= '{converter_on: 1'b0, burst_mode_sel: 1'b0,
                  ten_bit_mode: 1'b1, sar_div: SAR_DIV_RESET};
      end
      else if (do_write)
      begin
         if (aw_addr == POWER_CTL_ADDR && w_strb[0])
         begin
            pwr.converter_low_power_sel <= w_data[LOW_POWER_BIT];
            pwr.powerup_delay_code      <= w_data[DELAY_MSB:DELAY_LSB];
         end
         else if (aw_addr == CONV_CTL_ADDR)
         begin
            if (w_strb[0])
            begin
               cfg.converter_on   <= w_data[CONV_ON_BIT];
               cfg.burst_mode_sel <= w_data[BURST_SEL_BIT];
               cfg.ten_bit_mode   <= w_data[TEN_BIT_MODE_BIT];
            end
            if (w_strb[1])
               cfg.sar_div <= w_data[SAR_DIV_MSB:SAR_DIV_LSB];
         end
      end
   end

   // ************************************************************
   // AXI4-Lite read path
   // ************************************************************
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            if (s_axi_araddr == POWER_CTL_ADDR)
               s_axi_rdata <= {24'h000000, pwr.converter_low_power_sel, 3'h0,
                               pwr.powerup_delay_code};
            else if (s_axi_araddr == CONV_CTL_ADDR)
               s_axi_rdata <= {16'h0000, cfg.sar_div, 5'h00, cfg.ten_bit_mode,
                               cfg.burst_mode_sel, cfg.converter_on};
            else if (s_axi_araddr == STATUS_ADDR)
               s_axi_rdata <= {28'h0000000, conv_done, conv_low_power,
                               conv_busy, conv_powered};
            else
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // ************************************************************
   // Power and conversion sequencer
   // ************************************************************
   // Wait in core cycles, never shorter than (code + 1) * 400 ns
   wire [11:0] wake_cycles = 12'((32'(pwr.powerup_delay_code) + 32'd1)
                                 * DELAY_STEP_CYCLES);
   wire [3:0]  sar_len = cfg.ten_bit_mode ? 4'(CONV_SAR_10BIT) : 4'(CONV_SAR_8BIT);
   wire        stay_on = !cfg.burst_mode_sel ? cfg.converter_on
                                             : cfg.converter_on;
   wire        burst_sleep = cfg.burst_mode_sel && !cfg.converter_on;

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state          <= ABPC_OFF;
         wake_cnt       <= 12'h000;
         div_cnt        <= 8'h00;
         sar_cnt        <= 4'h0;
         start_pend     <= 1'b0;
         conv_powered   <= 1'b0;
         conv_busy      <= 1'b0;
         conv_done      <= 1'b0;
         conv_low_power <= 1'b0;
      end
      else
      begin
         conv_low_power <= pwr.converter_low_power_sel;
         conv_done      <= 1'b0;
         // A start during a conversion is held for the next one
         if (conv_start && state == ABPC_CONV)
            start_pend <= 1'b1;
         case (state)
            ABPC_OFF:
            begin
               conv_powered <= stay_on;
               if (stay_on)
                  state <= ABPC_IDLE;
               else if (burst_sleep && (conv_start || start_pend))
               begin
                  start_pend   <= 1'b0;
                  conv_powered <= 1'b1;
                  wake_cnt     <= wake_cycles;
                  state        <= ABPC_WAKE;
               end
            end
            ABPC_IDLE:
            begin
               if (!stay_on)
               begin
                  conv_powered <= 1'b0;
                  state        <= ABPC_OFF;
               end
               else if (cfg.burst_mode_sel && (conv_start || start_pend))
               begin
                  start_pend <= 1'b0;
                  conv_busy  <= 1'b1;
                  div_cnt    <= cfg.sar_div;
                  sar_cnt    <= sar_len;
                  state      <= ABPC_CONV;
               end
            end
            ABPC_WAKE:
            begin
               if (wake_cnt == 12'h001)
               begin
                  conv_busy <= 1'b1;
                  div_cnt   <= cfg.sar_div;
                  sar_cnt   <= sar_len;
                  state     <= ABPC_CONV;
               end
               wake_cnt <= wake_cnt - 12'h001;
            end
            ABPC_CONV:
            begin
               // One SAR clock per (sar_div + 1) core cycles
               if (div_cnt == 8'h00)
               begin
                  div_cnt <= cfg.sar_div;
                  sar_cnt <= sar_cnt - 4'h1;
                  if (sar_cnt == 4'h1)
                  begin
                     conv_busy <= 1'b0;
                     conv_done <= 1'b1;
                     if (stay_on)
                        state <= ABPC_IDLE;
                     else
                     begin
                        conv_powered <= 1'b0;
                        state        <= ABPC_OFF;
                     end
                  end
               end
               else
                  div_cnt <= div_cnt - 8'h01;
            end
            default:
               state <= ABPC_OFF;
         endcase
      end
   end

endmodule

//--- tb/abpc_asserts.sv
// Port checker for the burst power control block.
// Assumes one core_clk domain with a synchronous reset.
`timescale 1ns/1ps
module abpc_asserts
   import abpc_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        conv_powered,
   input wire logic        conv_low_power,
   input wire logic        conv_busy,
   input wire logic        conv_done
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   logic [7:0] pwr_age;
   logic [7:0] busy_len;
   // Saturates so a long-powered converter never looks freshly woken
   always_ff @(posedge core_clk)
      if (sys_rst || !conv_powered)
         pwr_age <= 8'h00;
      else if (pwr_age != 8'hff)
         pwr_age <= pwr_age + 8'h01;
   // Saturates so a slow conversion never wraps back below the minimum
   always_ff @(posedge core_clk)
      if (sys_rst || !conv_busy)
         busy_len <= 8'h00;
      else if (busy_len != 8'hff)
         busy_len <= busy_len + 8'h01;
   // ************************************************************
   // Properties
   // ************************************************************
   wake_wait_a: assert property ($rose(conv_busy) |-> pwr_age >= 8'h28)
      else $error("conversion began before the power-up wait");
   conv_length_a: assert property ($fell(conv_busy) |-> busy_len >= 8'h0b)
      else $error("conversion shorter than eleven cycles");
   busy_powered_a: assert property (conv_busy |-> conv_powered)
      else $error("busy while unpowered");
   done_pulse_a: assert property (conv_done |=> !conv_done)
      else $error("done longer than one cycle");
   done_ends_a: assert property (conv_done |-> ##[0:1] !conv_busy)
      else $error("busy stayed after done");
   // Write response rises with the register update, mirror follows a cycle later
   low_power_write_a: assert property ($changed(conv_low_power) |->
      $past(s_axi_bvalid))
      else $error("low power mode changed without a write");
   ready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
      else $error("awready longer than one cycle");
   resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped before bready");
   read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data moved before rready");
   cover property ($rose(conv_busy) && pwr_age < 8'hff);
   cover property (conv_done && conv_powered);
   cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule

bind abpc_top abpc_asserts i_abpc_asserts (.core_clk(core_clk), .sys_rst(sys_rst),
   .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .conv_powered(conv_powered),
   .conv_low_power(conv_low_power), .conv_busy(conv_busy), .conv_done(conv_done));

//--- tb/test_abpc_top.sv
// Self-checking bench for the burst power control block.
// Drives the register bus and start input itself; 100 MHz clock.
`timescale 1ns/1ps
module test_abpc_top;
   import abpc_pkg::*;
   logic core_clk = 1'b0, sys_rst = 1'b1, conv_start = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, seen;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic conv_powered, conv_low_power, conv_busy, conv_done;
   int mismatches = 0, comparisons = 0, wn, bn, n;
   int codes[3] = '{0, 4, 15};
   int cfgs[3] = '{32'h7, 32'h3, 32'h107};
   int lens[3] = '{13, 11, 26};
   abpc_top i_abpc_top (.core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .conv_start(conv_start), .conv_powered(conv_powered),
      .conv_low_power(conv_low_power), .conv_busy(conv_busy), .conv_done(conv_done));
   initial forever #5 core_clk = ~core_clk;
   // ************************************************************
   // Shared tasks
   // ************************************************************
   task stop_test();
      $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task hung(input int cnt);
      if (cnt >= 1000)
      begin
         mismatches++;
         stop_test();
      end
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
      n = 0;
      while (!s_axi_bvalid && n < 1000)
      begin
         @(posedge core_clk);
         n++;
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      hung(n);
      // Late bready so the held response is seen waiting
      s_axi_bready <= 1'b1;
      @(posedge core_clk);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task rdr(input logic [11:0] a);
      @(posedge core_clk);
      {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
      n = 0;
      while (!s_axi_rvalid && n < 1000)
      begin
         @(posedge core_clk);
         n++;
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      hung(n);
      s_axi_rready <= 1'b1;
      @(posedge core_clk);
      {rd, rsp} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask
   task fire();
      @(posedge core_clk);
      conv_start <= 1'b1;
      @(posedge core_clk);
      conv_start <= 1'b0;
      for (wn = 1; !conv_busy && wn < 1000; wn++) @(posedge core_clk);
      hung(wn);
      for (bn = 0; conv_busy && bn < 1000; bn++) @(posedge core_clk);
      hung(bn);
      seen = conv_done;
      repeat (3) @(posedge core_clk);
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task t_regs();
      rdr(POWER_CTL_ADDR); chk("pwr reset", rd, 32'h0f);
      chk("rd ok", 32'(rsp), 32'(RESP_OKAY));
      rdr(CONV_CTL_ADDR); chk("conv reset", rd, 32'h0c04);
      wr(POWER_CTL_ADDR, 32'hff); chk("lp on", 32'(conv_low_power), 32'h1);
      chk("wr ok", 32'(rsp), 32'(RESP_OKAY));
      rdr(STATUS_ADDR); chk("status lp", rd, 32'h4);
      rdr(POWER_CTL_ADDR); chk("pwr ff", rd, 32'h8f);
      wr(POWER_CTL_ADDR, 32'h70); rdr(POWER_CTL_ADDR); chk("pwr 70", rd, 32'h0);
      chk("lp off", 32'(conv_low_power), 32'h0);
      rdr(12'h010); chk("bad rd", {rd[29:0], rsp}, {30'h0, RESP_SLVERR});
      wr(12'h010, 32'h1); chk("bad wr", 32'(rsp), 32'(RESP_SLVERR));
   endtask
   task t_noburst();
      wr(POWER_CTL_ADDR, 32'h0f); chk("off", 32'(conv_powered), 32'h0);
      wr(CONV_CTL_ADDR, 32'h1); chk("on", 32'(conv_powered), 32'h1);
      rdr(STATUS_ADDR); chk("status on", rd, 32'h1);
      conv_start <= 1'b1;
      seen = 1'b0;
      repeat (60) @(posedge core_clk) {conv_start, seen} <= {1'b0, seen | conv_busy};
      chk("no conv", 32'(seen), 32'h0);
      wr(CONV_CTL_ADDR, 32'h0); chk("follow", 32'(conv_powered), 32'h0);
   endtask
   task t_awake();
      for (int i = 0; i < 3; i++)
      begin
         wr(CONV_CTL_ADDR, cfgs[i]);
         repeat (50) @(posedge core_clk);
         fire();
         chk("no wait", 32'(wn <= 2), 32'h1);
         chk("len", 32'(bn >= lens[i] && bn <= lens[i] + 1), 32'h1);
         chk("stay", 32'(conv_powered), 32'h1);
         chk("done", 32'(seen), 32'h1);
      end
   endtask
   task t_sleep();
      for (int i = 0; i < 3; i++)
      begin
         wr(POWER_CTL_ADDR, codes[i]);
         wr(CONV_CTL_ADDR, 32'h2); chk("asleep", 32'(conv_powered), 32'h0);
         fire();
         n = 40 * (codes[i] + 1);
         chk("wake", 32'(wn >= n && wn <= n + 3), 32'h1);
         chk("resleep", 32'(conv_powered), 32'h0);
         chk("sleep done", 32'(seen), 32'h1);
      end
   endtask
   initial
   begin
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      t_regs();
      t_noburst();
      t_awake();
      t_sleep();
      stop_test();
   end
endmodule
